// ---- swap_skip_table_xor_exec.sv ----
// execution unit for nibble swap, zero skips, table reads and xor
//
// Added by the designer: the Wishbone register port and the register addresses.
`timescale 1ns/1ns
`include "swap_skip_params.svh"

module swap_skip_table_xor_exec #(
  parameter int MEM_DEPTH = 64,
  parameter int PC_W      = 12,
  parameter int PROG_W    = 16
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // wishbone slave
  input  wire swap_skip_pkg::wbReq_t  wbReq,
  output logic                        wbAck,
  output logic [31:0]                 wbDatOut,
  // program memory read port
  output logic                        progReq,
  output logic [PC_W-1:0]             progAddr,
  input  wire logic [PROG_W-1:0]      progWord,
  // status
  output logic                        execBusy
);
  import swap_skip_pkg::*;

  // one instruction runs at a time: software launches it through the
  // command register and polls the busy bit before the next one

  // derived widths: memory index, program page and table latch high byte
  localparam int IDX_W  = $clog2(MEM_DEPTH);
  localparam int PAGE_W = PC_W - 8;
  localparam int HI_W   = PROG_W - 8;

  // ****************************************************************
  // state
  // ****************************************************************
  // sequencer and architectural state
  state_t              state_ff,       nxt_state;
  cmd_t                cmd_ff,         nxt_cmd;
  logic [7:0]          accum_ff,       nxt_accum;
  logic                zero_ff,        nxt_zero;
  logic                skipTaken_ff,   nxt_skipTaken;
  logic                busy_ff,        nxt_busy;
  logic [7:0]          tableLowPtr_ff, nxt_tableLowPtr;
  logic [7:0]          tableHighPtr_ff, nxt_tableHighPtr;
  logic [HI_W-1:0]     tableHighLatch_ff, nxt_tableHighLatch;
  logic [PC_W-1:0]     pc_ff,          nxt_pc;
  // program port and bus answer, registered so every output is a flop
  logic                progReq_ff,     nxt_progReq;
  logic [PC_W-1:0]     progAddr_ff,    nxt_progAddr;
  logic                wbAck_ff,       nxt_wbAck;
  logic [31:0]         wbDat_ff,       nxt_wbDat;
  // data memory, one byte per entry
  logic [7:0]          mem_ff [MEM_DEPTH];

  // ****************************************************************
  // combinational helpers
  // ****************************************************************
  // memory write port, shared by the bus and the instruction path
  logic                memWe;
  logic [IDX_W-1:0]    memIdx;
  logic [7:0]          memWrData;
  logic [7:0]          memOperand;
  // bus decode
  logic                busHit;
  logic                busWrite;
  logic                memWin;
  logic [IDX_W-1:0]    busIdx;
  logic [31:0]         rdData;
  logic                isTable;
  aluRes_t             aluRes;

  assign wbAck    = wbAck_ff;
  assign wbDatOut = wbDat_ff;
  assign progReq  = progReq_ff;
  assign progAddr = progAddr_ff;
  assign execBusy = busy_ff;

  // datapath for the non-table instructions
  exec_alu alu (
    .cmd     (cmd_ff),
    .accum   (accum_ff),
    .memByte (memOperand),
    .res     (aluRes)
  );

  // ****************************************************************
  // bus decode and read mux
  // ****************************************************************
  // a write takes effect on the edge where ack is already high
  always_comb begin
    busHit     = wbReq.cyc & wbReq.stb;
    busWrite   = busHit & wbReq.we & wbAck_ff;
    memWin     = (wbReq.adr[`WB_ADR_W-1:8] == `MEM_WIN_SEL);
    busIdx     = wbReq.adr[IDX_W+1:2];
    memOperand = mem_ff[cmd_ff.addr[IDX_W-1:0]];
    isTable    = (cmd_ff.op == OP_TABLE_READ_SPECIFIC_PAGE) ||
                 (cmd_ff.op == OP_TABLE_READ_CURRENT_PAGE) ||
                 (cmd_ff.op == OP_TABLE_READ_LAST_PAGE);
    rdData     = `WORD_RST;
    if (memWin) begin
      rdData[7:0] = mem_ff[busIdx];
    end else begin
      case (wbReq.adr)
        `REG_COMMAND: begin
          // same field layout as the write, so software reads back what it wrote
          rdData[`CMD_OP_LSB +: 4]   = cmd_ff.op;
          rdData[`CMD_BIT_LSB +: 3]  = cmd_ff.bitSel;
          rdData[`CMD_ADDR_LSB +: 8] = cmd_ff.addr;
          rdData[`CMD_IMM_LSB +: 8]  = cmd_ff.imm;
        end
        `REG_ACCUMULATOR: rdData[7:0] = accum_ff;
        `REG_STATUS: begin
          rdData[`ST_ZERO_BIT] = zero_ff;
          rdData[`ST_BUSY_BIT] = busy_ff;
          rdData[`ST_SKIP_BIT] = skipTaken_ff;
        end
        `REG_TLOW_PTR:    rdData[7:0] = tableLowPtr_ff;
        `REG_THIGH_PTR:   rdData[7:0] = tableHighPtr_ff;
        `REG_THIGH_LATCH: rdData[HI_W-1:0] = tableHighLatch_ff;
        `REG_PROG_CNT:    rdData[PC_W-1:0] = pc_ff;
        default:          rdData = `WORD_RST;
      endcase
    end
  end

  // ****************************************************************
  // next-state logic: bus writes and instruction sequencing
  // ****************************************************************
  // bus writes are honoured only while idle, so software can never
  // race an instruction that is half way through its cycles
  always_comb begin
    nxt_state          = state_ff;
    nxt_cmd            = cmd_ff;
    nxt_accum          = accum_ff;
    nxt_zero           = zero_ff;
    nxt_skipTaken      = skipTaken_ff;
    nxt_busy           = busy_ff;
    nxt_tableLowPtr    = tableLowPtr_ff;
    nxt_tableHighPtr   = tableHighPtr_ff;
    nxt_tableHighLatch = tableHighLatch_ff;
    nxt_pc             = pc_ff;
    nxt_progReq        = 1'b0;
    nxt_progAddr       = progAddr_ff;
    nxt_wbAck          = busHit & ~wbAck_ff;
    nxt_wbDat          = (busHit & ~wbAck_ff) ? rdData : `WORD_RST;
    memWe              = 1'b0;
    memIdx             = cmd_ff.addr[IDX_W-1:0];
    memWrData          = `BYTE_RST;
    case (state_ff)
      S_IDLE: begin
        if (busWrite && memWin && wbReq.sel[0]) begin
          memWe     = 1'b1;
          memIdx    = busIdx;
          memWrData = wbReq.dat[7:0];
        // register writes need byte lane 0 (the pc also lane 1, the command all four); a write without lane 0 is ignored
        end else if (busWrite && wbReq.sel[0]) begin
          case (wbReq.adr)
            `REG_COMMAND: begin
              if (wbReq.sel == `FULL_SEL) begin
                nxt_cmd.op     = op_t'(wbReq.dat[`CMD_OP_LSB +: 4]);
                nxt_cmd.bitSel = wbReq.dat[`CMD_BIT_LSB +: 3];
                nxt_cmd.addr   = wbReq.dat[`CMD_ADDR_LSB +: 8];
                nxt_cmd.imm    = wbReq.dat[`CMD_IMM_LSB +: 8];
                nxt_skipTaken  = 1'b0;
                nxt_busy       = 1'b1;
                nxt_state      = S_EXEC;
              end
            end
            `REG_ACCUMULATOR: nxt_accum        = wbReq.dat[7:0];
            `REG_TLOW_PTR:    nxt_tableLowPtr  = wbReq.dat[7:0];
            `REG_THIGH_PTR:   nxt_tableHighPtr = wbReq.dat[7:0];
            `REG_PROG_CNT: begin
              if (wbReq.sel[1]) begin
                nxt_pc = wbReq.dat[PC_W-1:0];
              end
            end
            default: nxt_pc = pc_ff;
          endcase
        end
      end
      S_EXEC: begin
        if (isTable) begin
          // fetch the program word; it returns one cycle later
          nxt_progReq = 1'b1;
          nxt_state   = S_TABLE;
          // page bits from the high pointer, the pc of this instruction or all ones
          case (cmd_ff.op)
            OP_TABLE_READ_SPECIFIC_PAGE:
              nxt_progAddr = {tableHighPtr_ff[PAGE_W-1:0], tableLowPtr_ff};
            OP_TABLE_READ_CURRENT_PAGE:
              nxt_progAddr = {pc_ff[PC_W-1:8], tableLowPtr_ff};
            default:
              nxt_progAddr = {{PAGE_W{1'b1}}, tableLowPtr_ff};
          endcase
        end else begin
          // zero is written only by the xor ops; the skip flag is set here when a skip is taken
          if (aluRes.accWe) begin
            nxt_accum = aluRes.acc;
          end
          if (aluRes.zeroWe) begin
            nxt_zero = aluRes.zero;
          end
          memWe     = aluRes.memWe;
          memWrData = aluRes.mem;
          nxt_pc    = PC_W'(pc_ff + 1'b1);
          if (aluRes.skip) begin
            nxt_skipTaken = 1'b1;
            nxt_state     = S_DUMMY;
          end else begin
            nxt_busy  = 1'b0;
            nxt_state = S_IDLE;
          end
        end
      end
      S_TABLE: begin
        // low byte to data memory, high byte to the latch, flags kept
        // progWord is only looked at here, in the same cycle that progReq is high
        memWe              = 1'b1;
        memWrData          = progWord[7:0];
        nxt_tableHighLatch = progWord[PROG_W-1:8];
        nxt_pc             = PC_W'(pc_ff + 1'b1);
        nxt_busy           = 1'b0;
        nxt_state          = S_IDLE;
      end
      S_DUMMY: begin
        // nothing is fetched here: the skipped instruction is passed over by a second pc increment
        nxt_pc    = PC_W'(pc_ff + 1'b1);
        nxt_busy  = 1'b0;
        nxt_state = S_IDLE;
      end
      // unused encoding: recover to idle rather than hang with busy set
      default: begin
        nxt_busy  = 1'b0;
        nxt_state = S_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  // control and bus state
  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff          <= S_IDLE;
      cmd_ff            <= '0;
      accum_ff          <= `BYTE_RST;
      zero_ff           <= 1'b0;
      skipTaken_ff      <= 1'b0;
      busy_ff           <= 1'b0;
      tableLowPtr_ff    <= `BYTE_RST;
      tableHighPtr_ff   <= `BYTE_RST;
      tableHighLatch_ff <= '0;
      pc_ff             <= '0;
      progReq_ff        <= 1'b0;
      progAddr_ff       <= '0;
      wbAck_ff          <= 1'b0;
      wbDat_ff          <= `WORD_RST;
    end else begin
      state_ff          <= nxt_state;
      cmd_ff            <= nxt_cmd;
      accum_ff          <= nxt_accum;
      zero_ff           <= nxt_zero;
      skipTaken_ff      <= nxt_skipTaken;
      busy_ff           <= nxt_busy;
      tableLowPtr_ff    <= nxt_tableLowPtr;
      tableHighPtr_ff   <= nxt_tableHighPtr;
      tableHighLatch_ff <= nxt_tableHighLatch;
      pc_ff             <= nxt_pc;
      progReq_ff        <= nxt_progReq;
      progAddr_ff       <= nxt_progAddr;
      wbAck_ff          <= nxt_wbAck;
      wbDat_ff          <= nxt_wbDat;
    end
  end

  // ****************************************************************
  // data memory
  // ****************************************************************
  // one byte per entry, cleared by reset so reads are defined; the wide
  // reset costs area but keeps a read of an unwritten byte from being unknown
  for (genvar i = 0; i < MEM_DEPTH; i++) begin : g_mem
    always_ff @(posedge clock) begin
      if (rst) begin
        mem_ff[i] <= `BYTE_RST;
      end else if (memWe && (memIdx == IDX_W'(i))) begin
        mem_ff[i] <= memWrData;
      end
    end
  end

endmodule : swap_skip_table_xor_exec

// ---- swap_skip_params.svh ----
// constants for the swap, skip, table read and xor execution unit
`ifndef SWAP_SKIP_PARAMS_SVH
`define SWAP_SKIP_PARAMS_SVH

// ****************************************************************
// wishbone register map (byte addresses)
// ****************************************************************
`define WB_ADR_W        10
`define REG_COMMAND     10'h000
`define REG_ACCUMULATOR 10'h004
`define REG_STATUS      10'h008
`define REG_TLOW_PTR    10'h00C
`define REG_THIGH_PTR   10'h010
`define REG_THIGH_LATCH 10'h014
`define REG_PROG_CNT    10'h018
`define MEM_WIN_SEL     2'h1

// ****************************************************************
// field positions
// ****************************************************************
`define CMD_OP_LSB      0
`define CMD_BIT_LSB     4
`define CMD_ADDR_LSB    8
`define CMD_IMM_LSB     16
`define ST_ZERO_BIT     0
`define ST_BUSY_BIT     1
`define ST_SKIP_BIT     2

// ****************************************************************
// reset values
// ****************************************************************
`define BYTE_RST        8'h00
`define WORD_RST        32'h0000_0000
`define FULL_SEL        4'hF

`endif

// ---- swap_skip_pkg.sv ----
// types shared by the execution unit and its datapath module
`include "swap_skip_params.svh"

package swap_skip_pkg;

  // opcodes carried in the command register
  typedef enum logic [3:0] {
    OP_NONE,
    OP_NIBBLE_EXCHANGE,
    OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR,
    OP_SKIP_IF_ZERO,
    OP_COPY_AND_SKIP_IF_ZERO,
    OP_SKIP_IF_BIT_ZERO,
    OP_TABLE_READ_SPECIFIC_PAGE,
    OP_TABLE_READ_CURRENT_PAGE,
    OP_TABLE_READ_LAST_PAGE,
    OP_XOR_TO_ACCUMULATOR,
    OP_EXCLUSIVE_OR_TO_MEMORY,
    OP_XOR_IMMEDIATE
  } op_t;

  typedef enum logic [1:0] {S_IDLE, S_EXEC, S_TABLE, S_DUMMY} state_t;

  // one decoded instruction
  typedef struct packed {
    logic [7:0] imm;
    logic [7:0] addr;
    logic [2:0] bitSel;
    op_t        op;
  } cmd_t;

  // wishbone request from the master
  typedef struct packed {
    logic                 cyc;
    logic                 stb;
    logic                 we;
    logic [3:0]           sel;
    logic [`WB_ADR_W-1:0] adr;
    logic [31:0]          dat;
  } wbReq_t;

  // datapath result of one instruction
  typedef struct packed {
    logic       accWe;
    logic [7:0] acc;
    logic       memWe;
    logic [7:0] mem;
    logic       zeroWe;
    logic       zero;
    logic       skip;
  } aluRes_t;

endpackage : swap_skip_pkg

// ---- exec_alu.sv ----
// combinational datapath for swap, skip and xor instructions
`timescale 1ns/1ns

module exec_alu (
  // operands
  input  wire swap_skip_pkg::cmd_t    cmd,
  input  wire logic [7:0]             accum,
  input  wire logic [7:0]             memByte,
  // result
  output swap_skip_pkg::aluRes_t      res
);
  import swap_skip_pkg::*;

  logic [7:0] xorMem;
  logic [7:0] xorImm;
  logic [7:0] swapped;

  // shared operand forms
  always_comb begin
    xorMem  = accum ^ memByte;
    xorImm  = accum ^ cmd.imm;
    swapped = {memByte[3:0], memByte[7:4]};
  end

  // per-opcode effects; anything not named leaves every target alone
  always_comb begin
    res = '0;
    case (cmd.op)
      OP_NIBBLE_EXCHANGE: begin
        res.memWe = 1'b1;
        res.mem   = swapped;
      end
      OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR: begin
        res.accWe = 1'b1;
        res.acc   = swapped;
      end
      OP_SKIP_IF_ZERO: begin
        res.skip = (memByte == 8'h00);
      end
      OP_COPY_AND_SKIP_IF_ZERO: begin
        res.accWe = 1'b1;
        res.acc   = memByte;
        res.skip  = (memByte == 8'h00);
      end
      OP_SKIP_IF_BIT_ZERO: begin
        res.skip = ~memByte[cmd.bitSel];
      end
      OP_XOR_TO_ACCUMULATOR: begin
        res.accWe  = 1'b1;
        res.acc    = xorMem;
        res.zeroWe = 1'b1;
        res.zero   = (xorMem == 8'h00);
      end
      OP_EXCLUSIVE_OR_TO_MEMORY: begin
        res.memWe  = 1'b1;
        res.mem    = xorMem;
        res.zeroWe = 1'b1;
        res.zero   = (xorMem == 8'h00);
      end
      OP_XOR_IMMEDIATE: begin
        res.accWe  = 1'b1;
        res.acc    = xorImm;
        res.zeroWe = 1'b1;
        res.zero   = (xorImm == 8'h00);
      end
      default: begin
        res = '0;
      end
    endcase
  end

endmodule : exec_alu

// ---- swap_skip_table_xor_exec_asserts.sv ----
// concurrent checks on the ports of the swap, skip, table read and xor unit
`timescale 1ns/1ns
`include "swap_skip_params.svh"

// ****************************************************************
// checker
// ****************************************************************
module swap_skip_table_xor_exec_asserts #(
  parameter int PC_W   = 12,
  parameter int PROG_W = 16
) (
  // clock and reset
  input wire logic                  clock,
  input wire logic                  rst,
  // bus and program port
  input wire swap_skip_pkg::wbReq_t wbReq,
  input wire logic                  wbAck,
  input wire logic [31:0]           wbDatOut,
  input wire logic                  progReq,
  input wire logic [PC_W-1:0]       progAddr,
  input wire logic [PROG_W-1:0]     progWord,
  input wire logic                  execBusy
);
  import swap_skip_pkg::*;
  logic       cmdLaunch;
  logic [3:0] lastOp_ff;
  logic [3:0] nxt_lastOp;

  // a full-width command write acked while idle launches an instruction
  assign cmdLaunch = wbAck && wbReq.we && wbReq.adr == `REG_COMMAND
                     && wbReq.sel == `FULL_SEL && !execBusy;

  // remember the opcode so the page of a table fetch can be judged
  always_comb begin
    nxt_lastOp = cmdLaunch ? wbReq.dat[3:0] : lastOp_ff;
  end
  always_ff @(posedge clock) begin
    lastOp_ff <= rst ? 4'h0 : nxt_lastOp;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  a_ack_pulse: assert property (wbAck |=> !wbAck)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property (wbReq.cyc && wbReq.stb && !wbAck |=> wbAck)
    else $error("request not acked in the next cycle");
  a_dat_idle: assert property (!wbAck |-> wbDatOut == 32'h0000_0000)
    else $error("read data not zero outside ack");
  a_busy_start: assert property (cmdLaunch && wbReq.dat[3:0] inside {[4'h1:4'hB]}
    |=> execBusy) else $error("command did not start execution");
  a_busy_bound: assert property ($rose(execBusy) |-> ##[1:2] !execBusy)
    else $error("instruction longer than two cycles");
  a_prog_pulse: assert property (progReq |=> !progReq)
    else $error("program request longer than one cycle");
  a_table_fetch: assert property (progReq |-> $past(execBusy) ##1 !execBusy)
    else $error("table fetch out of step with busy");
  a_last_page: assert property (progReq && lastOp_ff == 4'h8 |-> &progAddr[PC_W-1:8])
    else $error("last page fetch not on all-ones page");
  a_addr_hold: assert property (!progReq |-> $stable(progAddr))
    else $error("program address moved without request");
  a_idle_quiet: assert property (!execBusy |-> !progReq)
    else $error("program request while idle");
endmodule : swap_skip_table_xor_exec_asserts

bind swap_skip_table_xor_exec swap_skip_table_xor_exec_asserts #(
  .PC_W(PC_W), .PROG_W(PROG_W)) swap_skip_table_xor_exec_asserts_i (
  .clock(clock), .rst(rst), .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut),
  .progReq(progReq), .progAddr(progAddr), .progWord(progWord), .execBusy(execBusy));

// ---- tb_top.sv ----
// self-checking testbench for the swap, skip, table read and xor unit
`timescale 1ns/1ns
`include "swap_skip_params.svh"

// ****************************************************************
// testbench
// ****************************************************************
module tb_top;
  import swap_skip_pkg::*;
  logic                 clock, rst, wbAck, progReq, execBusy;
  wbReq_t               wbReq;
  logic [31:0]          wbDatOut;
  logic [11:0]          progAddr, mPc;
  logic [15:0]          progWord;
  logic [7:0]           mAcc, mTlow, mThigh, mTlatch, mMem [64];
  logic                 mZero, mSkip;
  logic [5:0]           a;
  int                   mismatches, numChecks, cycles, seed;

  swap_skip_table_xor_exec swap_skip_table_xor_exec_i (.clock(clock), .rst(rst),
    .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut), .progReq(progReq),
    .progAddr(progAddr), .progWord(progWord), .execBusy(execBusy));

  always #20 clock = ~clock;

  // program memory contents follow the address so every page gives its own word
  function automatic logic [15:0] romWord(input logic [11:0] pa);
    return {pa[7:0] ^ 8'h5A, pa[11:4] + 8'h33};
  endfunction : romWord
  function automatic logic [7:0] nib(input logic [7:0] v);
    return {v[3:0], v[7:4]};
  endfunction : nib
  always @(progAddr or rst) progWord = rst ? 16'h0000 : romWord(progAddr);

  // hang guard: a full run needs well under this many cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles > 20000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic stop_test;
    if (mismatches == 0 && numChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  // one classic cycle; waits for ack with no assumed latency
  task automatic wbXfer(input logic we, input logic [9:0] adr, input logic [31:0] dat,
                        output logic [31:0] rd);
    @(posedge clock);
    wbReq <= {2'b11, we, `FULL_SEL, adr, dat};
    // only the cycle ceiling ends a wait that never sees ack
    do begin
      @(posedge clock);
    end while (wbAck !== 1'b1);
    rd = wbDatOut;
    wbReq <= '0;
  endtask : wbXfer

  task automatic wr(input logic [9:0] adr, input logic [31:0] dat);
    logic [31:0] rd;
    wbXfer(1'b1, adr, dat, rd);
  endtask : wr

  task automatic chk(input logic [9:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    wbXfer(1'b0, adr, 32'h0, rd);
    numChecks++;
    if (rd !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: got %h expected %h", $time, rd, exp);
    end
  endtask : chk

  // load operands; status and latch writes must be ignored as read-only
  task automatic setup();
    a = 6'($random(seed));
    mMem[a] = ($random(seed) & 1) ? 8'h00 : 8'($random(seed));
    mAcc = 8'($random(seed));
    mTlow = 8'($random(seed));
    mThigh = 8'($random(seed));
    mPc = 12'($random(seed));
    wr(10'h100 + {2'b00, a, 2'b00}, {24'h0, mMem[a]});
    wr(`REG_ACCUMULATOR, {24'h0, mAcc});
    wr(`REG_TLOW_PTR, {24'h0, mTlow});
    wr(`REG_THIGH_PTR, {24'h0, mThigh});
    wr(`REG_PROG_CNT, {20'h0, mPc});
    wr(`REG_STATUS, 32'h0000_0007);
    wr(`REG_THIGH_LATCH, 32'h0000_00FF);
  endtask : setup

  // reference model of one instruction, then compare every register it touches
  task automatic runOp(input logic [3:0] op, input logic [2:0] bs, input logic [7:0] imm);
    logic [7:0]  m;
    logic [11:0] pa;
    logic [31:0] rd;
    m = mMem[a];
    mSkip = 1'b0;
    pa = 12'h000;
    case (op)
      4'h1: mMem[a] = nib(m);
      4'h2: mAcc = nib(m);
      4'h3: mSkip = (m == 8'h00);
      4'h4: begin
        mAcc = m;
        mSkip = (m == 8'h00);
      end
      4'h5: mSkip = !m[bs];
      4'h6: pa = {mThigh[3:0], mTlow};
      4'h7: pa = {mPc[11:8], mTlow};
      4'h8: pa = {4'hF, mTlow};
      4'h9: mAcc = mAcc ^ m;
      4'hA: mMem[a] = mAcc ^ m;
      4'hB: mAcc = mAcc ^ imm;
      default: ;
    endcase
    if (op inside {[4'h6:4'h8]}) {mTlatch, mMem[a]} = romWord(pa);
    if (op inside {[4'h9:4'hB]}) mZero = ((op == 4'hA ? mMem[a] : mAcc) == 8'h00);
    mPc = mPc + (mSkip ? 12'h002 : 12'h001);
    wr(`REG_COMMAND, {8'h00, imm, 2'b00, a, 1'b0, bs, op});
    do begin
      wbXfer(1'b0, `REG_STATUS, 32'h0, rd);
    end while (rd[`ST_BUSY_BIT] !== 1'b0);
    chk(`REG_STATUS, {29'h0, mSkip, 1'b0, mZero});
    chk(`REG_ACCUMULATOR, {24'h0, mAcc});
    chk(`REG_THIGH_LATCH, {24'h0, mTlatch});
    chk(`REG_PROG_CNT, {20'h0, mPc});
    chk(`REG_COMMAND, {8'h00, imm, 2'b00, a, 1'b0, bs, op});
    chk(10'h100 + {2'b00, a, 2'b00}, {24'h0, mMem[a]});
  endtask : runOp

  // ****************************************************************
  // main sequence: every opcode four times, memory operand zero at random half the time, then random
  // ****************************************************************
  initial begin
    seed = 32'h64143A3D;
    clock = 1'b0;
    rst = 1'b1;
    wbReq = '0;
    mismatches = 0;
    numChecks = 0;
    cycles = 0;
    foreach (mMem[i]) mMem[i] = 8'h00;
    {mAcc, mTlatch, mZero} = '0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    chk(10'h020, 32'h0000_0000);
    for (int op = 0; op < 12; op++) begin
      for (int k = 0; k < 4; k++) begin
        setup();
        runOp(4'(op), 3'($random(seed)), k == 0 ? mAcc : 8'($random(seed)));
      end
    end
    repeat (40) begin
      setup();
      runOp(4'($random(seed) % 12), 3'($random(seed)), 8'($random(seed)));
    end
    stop_test();
  end
endmodule : tb_top
